// ---- verilog/ssf_defines.vh ----
`ifndef SSF_DEFINES_VH
`define SSF_DEFINES_VH
// Function
// (RULE1) Config load with single-error correction sets test event bit 3
// (RULE2) Config load with double-bit error sets test event bit 2, no enable
// (RULE3) Self-test finish sets bit 1; write one clears; next run sets again
// (RULE4) Self-test fault sets bit 0; write one clears; recurs on next run
// (RULE5) Failed startup register check sets fault bit 7; write one clears
// (RULE6) Regulator fault bit 6, oscillator fault bit 4, write one clears
// (RULE7) Reset pin mismatch sets bit 5; write one clears only once gone
// (RULE8) Address pin short sets bit 3, open sets bit 2, write one clears
// (RULE9) Monitor state: bit 7 safe state, bit 6 self-test done, read-only
// (RULE10) Monitor state bits 5:1 mirror supply, irq, low-power, enable, tag
// (RULE11) Result bit 5 correction applied, bit 4 double error, last load
// (RULE12) Result bits 3:0 memory, nvm, logic, analog tests; one is fail
// (RULE13) Channel-off bits 7:0 set while channel below its off threshold
// (RULE14) Recording bit 7 set while recording, from enable, request, software
// (RULE15) Bits 6:5 give sequence: on, off, low-power exit, low-power entry
// (RULE16) Timestamp ready bit 4; without overwrite cleared by acknowledge
// (RULE17) With overwrite, timestamp ready clears after enabled channels read
// (RULE18) Timestamp ready while recording means timestamps are overwritten
// (RULE19) Log ready bits 3:0 per sequence; cleared by ack or by reads
// (RULE20) Log ready, recording and matching code means that log overwritten
// (RULE21) Zero writes keep flags; read-only and reserved ignore writes, read 0

// Register indices, byte address is four times the index
`define SSF_IDX_TEST    6'h23
`define SSF_IDX_FAULT   6'h24
`define SSF_IDX_MON     6'h30
`define SSF_IDX_RESULT  6'h31
`define SSF_IDX_OFF     6'h32
`define SSF_IDX_REC     6'h34
`define SSF_IDX_CFG     6'h3c
`define SSF_IDX_ACK     6'h3d
`define SSF_IDX_CHEN    6'h3e

// Test event bits
`define SSF_TE_SEC      3
`define SSF_TE_DED      2
`define SSF_TE_DONE     1
`define SSF_TE_FLT      0
// Internal fault bits
`define SSF_IF_CRC      7
`define SSF_IF_REG      6
`define SSF_IF_RST      5
`define SSF_IF_OSC      4
`define SSF_IF_SHORT    3
`define SSF_IF_OPEN     2
// Recording state bits
`define SSF_RS_ACT      7
`define SSF_RS_TS       4
// Configuration bits
`define SSF_CF_TSOW     0
`define SSF_CF_LOGOW    1
// Acknowledge bits (3:0 follow the log ready layout)
`define SSF_AK_TS       4
`define SSF_AK_REC      7

// Sequence codes
`define SSF_SEQ_ON      2'h0
`define SSF_SEQ_OFF     2'h1
`define SSF_SEQ_EXIT    2'h2
`define SSF_SEQ_ENTRY   2'h3

`define SSF_RST8        8'h00
`define SSF_CHEN_RST    8'hff
`define SSF_RESP_OKAY   2'h0
`define SSF_RESP_SLVERR 2'h2
`endif

// ---- verilog/ssf_sync2.v ----
`timescale 1ns/1ps
module ssf_sync2 #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // Data
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta_r;

    // First stage feeds only the second stage
    always @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= {W{1'b0}};
            q      <= {W{1'b0}};
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// ---- verilog/ssf_status_regs.v ----
`timescale 1ns/1ps
`include "ssf_defines.vh"
module ssf_status_regs (
    // Clock and reset
    input  wire        CORE_CLK,
    input  wire        RST_N,
    // AXI4-Lite write address and data
    input  wire [7:0]  AWADDR,
    input  wire        AWVALID,
    output reg         AWREADY,
    input  wire [31:0] WDATA,
    input  wire [3:0]  WSTRB,
    input  wire        WVALID,
    output reg         WREADY,
    // AXI4-Lite write response
    output reg  [1:0]  BRESP,
    output reg         BVALID,
    input  wire        BREADY,
    // AXI4-Lite read
    input  wire [7:0]  ARADDR,
    input  wire        ARVALID,
    output reg         ARREADY,
    output reg  [31:0] RDATA,
    output reg  [1:0]  RRESP,
    output reg         RVALID,
    input  wire        RREADY,
    // Configuration load and self-test events
    input  wire        CFG_LOAD_DONE,
    input  wire        CFG_SEC,
    input  wire        CFG_DED,
    input  wire        SELF_TEST_FAULT_EVENT_DONE,
    input  wire [3:0]  SELF_TEST_FAULT_EVENT_FAIL,
    input  wire        STARTUP_CHK_DONE,
    input  wire        STARTUP_CHK_FAIL,
    // Internal fault detectors
    input  wire        REG_FAULT,
    input  wire        OSC_FAULT,
    input  wire        ADDR_SHORT,
    input  wire        ADDR_OPEN,
    input  wire        RST_DRIVE,
    input  wire        SAFE_STATE,
    // Pins
    input  wire        RST_READBACK,
    input  wire        SUPPLY_PIN,
    input  wire        IRQ_PIN,
    input  wire        LOW_POWER_REQ,
    input  wire        POWER_ENABLE,
    input  wire        RAIL_TAG_PIN,
    input  wire [7:0]  CH_BELOW_OFF,
    // Sequence recording
    input  wire        REC_DONE,
    input  wire [7:0]  TS_RD_CH,
    input  wire [7:0]  LOG_RD_CH,
    input  wire [1:0]  LOG_RD_SEQ,
    output reg         RECORDING_IN_PROGRESS,
    output reg  [1:0]  REC_SEQ,
    output reg         TS_OVERWRITE,
    output reg  [3:0]  LOG_OVERWRITE
);
    function mapped;
        input [5:0] idx;
        begin
            case (idx)
                `SSF_IDX_TEST, `SSF_IDX_FAULT, `SSF_IDX_MON,
                `SSF_IDX_RESULT, `SSF_IDX_OFF, `SSF_IDX_REC,
                `SSF_IDX_CFG, `SSF_IDX_ACK, `SSF_IDX_CHEN: begin
                    mapped = 1'b1;
                end
                default: begin
                    mapped = 1'b0;
                end
            endcase
        end
    endfunction

    // Bus state
    reg        aw_hold_r;
    reg        w_hold_r;
    reg [5:0]  aw_idx_r;
    reg [7:0]  wdata_r;
    reg        wstrb0_r;

    // Register state
    reg [3:0]  test_r;
    reg [5:0]  fault_r;
    reg [5:0]  result_r;
    reg        st_done_r;
    reg [1:0]  cfg_r;
    reg [7:0]  chen_r;
    reg        rec_r;
    reg [1:0]  code_r;
    reg        timestamp_ready_r;
    reg [7:0]  ts_mask_r;
    reg [3:0]  lr_r;
    reg [7:0]  act_d_r;

    wire [13:0] pin_s;
    wire        rb_s;
    wire        vdd_s;
    wire        irq_s;
    wire        slp_s;
    wire        act_s;
    wire        tag_s;
    wire [7:0]  off_s;

    ssf_sync2 #(.W(14)) u_sync (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .d     ({RST_READBACK, SUPPLY_PIN, IRQ_PIN, LOW_POWER_REQ,
                 POWER_ENABLE, RAIL_TAG_PIN, CH_BELOW_OFF}),
        .q     (pin_s)
    );
    assign {rb_s, vdd_s, irq_s, slp_s, act_s, tag_s, off_s} = pin_s;

    // Write path: address and data may arrive in either order
    wire       aw_take = AWVALID & AWREADY;
    wire       w_take  = WVALID & WREADY;
    wire       wr_go   = aw_hold_r & w_hold_r & ~BVALID;
    wire       aw_hold_nxt = (aw_hold_r | aw_take) & ~wr_go;
    wire       w_hold_nxt  = (w_hold_r | w_take) & ~wr_go;
    wire       bvalid_nxt  = wr_go | (BVALID & ~BREADY);
    wire [7:0] wb = wstrb0_r ? wdata_r : `SSF_RST8;

    wire wr_test  = wr_go & (aw_idx_r == `SSF_IDX_TEST);
    wire wr_fault = wr_go & (aw_idx_r == `SSF_IDX_FAULT);
    wire wr_cfg   = wr_go & (aw_idx_r == `SSF_IDX_CFG);
    wire wr_ack   = wr_go & (aw_idx_r == `SSF_IDX_ACK);
    wire wr_chen  = wr_go & (aw_idx_r == `SSF_IDX_CHEN);

    always @(posedge CORE_CLK) begin
        if (!RST_N) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            aw_idx_r  <= 6'h00;
            wdata_r   <= `SSF_RST8;
            wstrb0_r  <= 1'b0;
            AWREADY   <= 1'b0;
            WREADY    <= 1'b0;
            BVALID    <= 1'b0;
            BRESP     <= `SSF_RESP_OKAY;
        end else begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r  <= w_hold_nxt;
            if (aw_take) begin
                aw_idx_r <= AWADDR[7:2];
            end
            if (w_take) begin
                wdata_r  <= WDATA[7:0];
                wstrb0_r <= WSTRB[0];
            end
            // Ready stays low while a write waits for its response
            AWREADY <= ~aw_hold_nxt & ~bvalid_nxt;
            WREADY  <= ~w_hold_nxt & ~bvalid_nxt;
            BVALID  <= bvalid_nxt;
            if (wr_go) begin
                BRESP <= mapped(aw_idx_r) ? `SSF_RESP_OKAY
                                          : `SSF_RESP_SLVERR;
            end
        end
    end

    // Software-written control
    wire [7:0] ack = wr_ack ? wb : `SSF_RST8;
    wire       ts_ow  = cfg_r[`SSF_CF_TSOW];
    wire       log_ow = cfg_r[`SSF_CF_LOGOW];
    // Log ready kept indexed by sequence code; register shows it reversed
    wire [3:0] ack_by_code = {ack[0], ack[1], ack[2], ack[3]};

    // Test events, set wins over a clear in the same cycle
    wire [3:0] test_set;
    assign test_set[`SSF_TE_SEC]  = CFG_LOAD_DONE & CFG_SEC;    // RULE1
    assign test_set[`SSF_TE_DED]  = CFG_LOAD_DONE & CFG_DED;    // RULE2
    assign test_set[`SSF_TE_DONE] = SELF_TEST_FAULT_EVENT_DONE;                  // RULE3
    assign test_set[`SSF_TE_FLT]  = SELF_TEST_FAULT_EVENT_DONE & (|SELF_TEST_FAULT_EVENT_FAIL);   // RULE4
    wire [3:0] test_clr = wr_test ? wb[3:0] : 4'h0;              // RULE21
    wire [3:0] test_nxt = (test_r & ~test_clr) | test_set;      // RULE3

    // Internal faults, stored as bits 7:2
    wire       mism = RST_DRIVE ^ rb_s;                         // RULE7
    wire [5:0] fault_set;
    assign fault_set[`SSF_IF_CRC-2]   = STARTUP_CHK_DONE &
                                        STARTUP_CHK_FAIL;       // RULE5
    assign fault_set[`SSF_IF_REG-2]   = REG_FAULT;              // RULE6
    assign fault_set[`SSF_IF_RST-2]   = mism;                   // RULE7
    assign fault_set[`SSF_IF_OSC-2]   = OSC_FAULT;              // RULE6
    assign fault_set[`SSF_IF_SHORT-2] = ADDR_SHORT;             // RULE8
    assign fault_set[`SSF_IF_OPEN-2]  = ADDR_OPEN;              // RULE8
    wire [5:0] fault_wclr = wr_fault ? wb[7:2] : 6'h00;
    wire [5:0] fault_clr;
    // Mismatch bit only yields to a clear once the pins agree again
    assign fault_clr = fault_wclr &
                       ~({5'h00, mism} << (`SSF_IF_RST-2));     // RULE7
    wire [5:0] fault_nxt = (fault_r & ~fault_clr) | fault_set;  // RULE6

    // Recording start detection on synchronised levels
    wire act_rise = act_s & ~act_d_r[0];
    wire act_fall = ~act_s & act_d_r[0];
    wire slp_rise = slp_s & ~act_d_r[1];
    wire slp_fall = ~slp_s & act_d_r[1];
    wire sw_start = ack[`SSF_AK_REC];
    wire start    = ~rec_r & (act_rise | act_fall | slp_rise |
                              slp_fall | sw_start);             // RULE14
    wire rec_end  = rec_r & REC_DONE;
    reg  [1:0] code_nxt;

    always @* begin
        code_nxt = code_r;
        if (start) begin
            if (act_rise) begin
                code_nxt = `SSF_SEQ_ON;                         // RULE15
            end else if (act_fall) begin
                code_nxt = `SSF_SEQ_OFF;
            end else if (slp_rise) begin
                code_nxt = `SSF_SEQ_EXIT;
            end else if (slp_fall) begin
                code_nxt = `SSF_SEQ_ENTRY;
            end else begin
                code_nxt = `SSF_SEQ_ON;
            end
        end
    end

    wire rec_nxt = (rec_r & ~REC_DONE) | start;                 // RULE14

    // Timestamp ready and its read tracking
    wire [7:0] ts_seen = ts_mask_r | TS_RD_CH;
    wire ts_all   = ((ts_seen & chen_r) == chen_r);
    wire ts_clr   = ts_ow ? ts_all                               // RULE17
                          : ack[`SSF_AK_TS];                     // RULE16
    wire timestamp_ready_nxt = (timestamp_ready_r & ~ts_clr) | rec_end;            // RULE16
    wire [7:0] ts_mask_nxt = rec_end ? `SSF_RST8
                           : (timestamp_ready_r ? ts_seen : ts_mask_r);

    // Per-sequence order log ready, indexed by code
    wire [3:0] lr_nxt;
    wire [3:0] lr_ow;
    genvar c;
    generate
        for (c = 0; c < 4; c = c + 1) begin : g_log
            reg  [7:0] mask_r;
            wire       hit  = (LOG_RD_SEQ == c);
            wire [7:0] seen = mask_r | (hit ? LOG_RD_CH : `SSF_RST8);
            wire       all  = ((seen & chen_r) == chen_r);
            wire       clr  = log_ow ? all : ack_by_code[c];    // RULE19
            wire       set  = rec_end & (code_r == c);
            assign lr_nxt[c] = (lr_r[c] & ~clr) | set;          // RULE19
            assign lr_ow[c]  = lr_nxt[c] & rec_nxt &
                               (code_nxt == c);                 // RULE20
            always @(posedge CORE_CLK) begin
                if (!RST_N) begin
                    mask_r <= `SSF_RST8;
                end else if (set) begin
                    mask_r <= `SSF_RST8;
                end else if (lr_r[c]) begin
                    mask_r <= seen;
                end
            end
        end
    endgenerate

    always @(posedge CORE_CLK) begin
        if (!RST_N) begin
            test_r        <= 4'h0;
            fault_r       <= 6'h00;
            result_r      <= 6'h00;
            st_done_r     <= 1'b0;
            cfg_r         <= 2'h0;
            chen_r        <= `SSF_CHEN_RST;
            rec_r         <= 1'b0;
            code_r        <= `SSF_SEQ_ON;
            timestamp_ready_r      <= 1'b0;
            ts_mask_r     <= `SSF_RST8;
            lr_r          <= 4'h0;
            act_d_r       <= 8'h00;
            RECORDING_IN_PROGRESS    <= 1'b0;
            REC_SEQ       <= `SSF_SEQ_ON;
            TS_OVERWRITE  <= 1'b0;
            LOG_OVERWRITE <= 4'h0;
        end else begin
            test_r    <= test_nxt;
            fault_r   <= fault_nxt;
            if (CFG_LOAD_DONE) begin
                result_r[5:4] <= {CFG_SEC, CFG_DED};            // RULE11
            end
            if (SELF_TEST_FAULT_EVENT_DONE) begin
                result_r[3:0] <= SELF_TEST_FAULT_EVENT_FAIL;                     // RULE12
                st_done_r     <= 1'b1;                          // RULE9
            end
            if (wr_cfg) begin
                cfg_r <= wb[1:0];
            end
            if (wr_chen) begin
                chen_r <= wb;
            end
            rec_r     <= rec_nxt;
            code_r    <= code_nxt;
            timestamp_ready_r  <= timestamp_ready_nxt;
            ts_mask_r <= ts_mask_nxt;
            lr_r      <= lr_nxt;
            act_d_r   <= {6'h00, slp_s, act_s};
            RECORDING_IN_PROGRESS    <= rec_nxt;
            REC_SEQ       <= code_nxt;
            TS_OVERWRITE  <= timestamp_ready_nxt & rec_nxt;              // RULE18
            LOG_OVERWRITE <= {lr_ow[0], lr_ow[1], lr_ow[2], lr_ow[3]};
        end
    end

    // Read path: one word in flight, data captured when the address is taken
    wire       ar_take = ARVALID & ARREADY;
    wire       rvalid_nxt = ar_take | (RVALID & ~RREADY);
    wire [5:0] ar_idx = ARADDR[7:2];
    reg  [7:0] rd_byte;

    always @* begin
        rd_byte = `SSF_RST8;
        case (ar_idx)
            `SSF_IDX_TEST: begin
                rd_byte = {4'h0, test_r};                       // RULE21
            end
            `SSF_IDX_FAULT: begin
                rd_byte = {fault_r, 2'h0};
            end
            `SSF_IDX_MON: begin
                rd_byte = {SAFE_STATE, st_done_r, vdd_s, irq_s,
                           slp_s, act_s, tag_s, 1'b0};          // RULE10
            end
            `SSF_IDX_RESULT: begin
                rd_byte = {2'h0, result_r};                     // RULE11
            end
            `SSF_IDX_OFF: begin
                rd_byte = off_s;                                // RULE13
            end
            `SSF_IDX_REC: begin
                rd_byte = {rec_r, code_r, timestamp_ready_r,
                           lr_r[0], lr_r[1], lr_r[2], lr_r[3]}; // RULE19
            end
            `SSF_IDX_CFG: begin
                rd_byte = {6'h00, cfg_r};
            end
            `SSF_IDX_CHEN: begin
                rd_byte = chen_r;
            end
            default: begin
                rd_byte = `SSF_RST8;
            end
        endcase
    end

    always @(posedge CORE_CLK) begin
        if (!RST_N) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b0;
            RDATA   <= 32'h0000_0000;
            RRESP   <= `SSF_RESP_OKAY;
        end else begin
            ARREADY <= ~rvalid_nxt;
            RVALID  <= rvalid_nxt;
            if (ar_take) begin
                RDATA <= {24'h00_0000, rd_byte};
                RRESP <= mapped(ar_idx) ? `SSF_RESP_OKAY
                                        : `SSF_RESP_SLVERR;
            end
        end
    end
endmodule

// ---- testbench/ssf_status_props.sv ----
`timescale 1ns/1ps
module ssf_status_props (
    // Clock and reset
    input wire        CORE_CLK,
    input wire        RST_N,
    // Register bus
    input wire        AWVALID,
    input wire        AWREADY,
    input wire        WVALID,
    input wire        WREADY,
    input wire        BVALID,
    input wire        ARVALID,
    input wire        ARREADY,
    input wire [31:0] RDATA,
    input wire        RVALID,
    input wire        RREADY,
    // Recording
    input wire        REC_DONE,
    input wire        RECORDING_IN_PROGRESS,
    input wire [1:0]  REC_SEQ,
    input wire        TS_OVERWRITE,
    input wire [3:0]  LOG_OVERWRITE
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);

    a_write_answer: assert property (
        AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID)
        else $error("write not answered in time");
    a_read_answer: assert property (
        ARVALID && ARREADY |=> RVALID)
        else $error("read not answered");
    a_rdata_hold: assert property (
        RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped before taken");
    a_rdata_upper: assert property (
        RVALID |-> RDATA[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_rec_end: assert property (
        RECORDING_IN_PROGRESS && REC_DONE |=> !RECORDING_IN_PROGRESS)
        else $error("recording did not end");
    a_seq_hold: assert property (
        RECORDING_IN_PROGRESS && !REC_DONE |=> RECORDING_IN_PROGRESS && $stable(REC_SEQ))
        else $error("recording state changed mid sequence");
    a_ts_overwrite: assert property (
        TS_OVERWRITE |-> RECORDING_IN_PROGRESS)
        else $error("timestamp overwrite while idle");
    a_log_overwrite: assert property (
        LOG_OVERWRITE != 4'h0 |-> RECORDING_IN_PROGRESS
        && LOG_OVERWRITE == (4'h8 >> REC_SEQ))
        else $error("log overwrite does not match sequence");

    c_ts_ow: cover property (TS_OVERWRITE);
    c_entry: cover property (RECORDING_IN_PROGRESS && REC_SEQ == 2'h3);
    c_rec_end: cover property (RECORDING_IN_PROGRESS && REC_DONE);
endmodule

bind ssf_status_regs ssf_status_props ssf_status_props_i (
    .CORE_CLK, .RST_N, .AWVALID, .AWREADY, .WVALID, .WREADY, .BVALID,
    .ARVALID, .ARREADY, .RDATA, .RVALID, .RREADY, .REC_DONE,
    .RECORDING_IN_PROGRESS, .REC_SEQ, .TS_OVERWRITE, .LOG_OVERWRITE
);

// ---- testbench/ssf_host_model.sv ----
`timescale 1ns/1ps
module ssf_host_model (
    // Clock
    input  wire        CORE_CLK,
    // Write channels
    output reg  [7:0]  AWADDR,
    output reg         AWVALID,
    input  wire        AWREADY,
    output reg  [31:0] WDATA,
    output reg  [3:0]  WSTRB,
    output reg         WVALID,
    input  wire        WREADY,
    input  wire [1:0]  BRESP,
    input  wire        BVALID,
    output reg         BREADY,
    // Read channels
    output reg  [7:0]  ARADDR,
    output reg         ARVALID,
    input  wire        ARREADY,
    input  wire [31:0] RDATA,
    input  wire [1:0]  RRESP,
    input  wire        RVALID,
    output reg         RREADY,
    // Wait limit used up
    output reg         HUNG
);
    initial begin
        {AWADDR, AWVALID, WDATA, WVALID, BREADY} = 43'h0;
        {ARADDR, ARVALID, RREADY, HUNG} = 11'h0;
        WSTRB = 4'h1;
    end

    // Valid flags are read before this edge's updates land, so each
    // channel drops exactly at the edge that took it
    task xfer(input wr, input [5:0] idx, input [7:0] wd,
              output [31:0] q, output [1:0] r);
        reg     b;
        integer n;
        begin
            b = 1'b1;
            if (wr) begin
                AWADDR <= {idx, 2'h0};
                WDATA <= {24'h0, wd};
                AWVALID <= 1'b1;
                WVALID <= 1'b1;
                BREADY <= 1'b1;
            end else begin
                ARADDR <= {idx, 2'h0};
                ARVALID <= 1'b1;
            end
            for (n = 0; b && n < 64; n = n + 1) begin
                @(posedge CORE_CLK);
                if (AWVALID && AWREADY)
                    AWVALID <= 1'b0;
                if (WVALID && WREADY)
                    WVALID <= 1'b0;
                if (ARVALID && ARREADY)
                    ARVALID <= 1'b0;
                // Read ready trails valid so the data hold is exercised
                if (!wr && RVALID && !RREADY)
                    RREADY <= 1'b1;
                if ((BREADY && BVALID) || (RREADY && RVALID)) begin
                    b = 1'b0;
                    q = RDATA;
                    r = wr ? BRESP : RRESP;
                    BREADY <= 1'b0;
                    RREADY <= 1'b0;
                end
            end
            if (b)
                HUNG <= 1'b1;
            @(posedge CORE_CLK);
        end
    endtask
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`include "ssf_defines.vh"
module tb_top;
    reg         CORE_CLK = 1'b0;
    reg         RST_N = 1'b0;
    reg         CFG_SEC = 1'b0, CFG_DED = 1'b0, STARTUP_CHK_FAIL = 1'b0;
    reg         RST_DRIVE = 1'b0, RST_READBACK = 1'b0;
    reg  [3:0]  SELF_TEST_FAULT_EVENT_FAIL = 4'h0;
    reg  [7:0]  CH_BELOW_OFF = 8'h00, TS_RD_CH = 8'h00, LOG_RD_CH = 8'h00;
    reg  [1:0]  LOG_RD_SEQ = 2'h0;
    reg  [7:0]  ev = 8'h00;
    reg  [5:0]  pins = 6'h00;
    wire [7:0]  AWADDR, ARADDR;
    wire [31:0] WDATA, RDATA;
    wire [3:0]  WSTRB, LOG_OVERWRITE;
    wire [1:0]  BRESP, RRESP, REC_SEQ;
    wire        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
    wire        ARVALID, ARREADY, RVALID, RREADY, hung;
    wire        RECORDING_IN_PROGRESS, TS_OVERWRITE;
    reg  [31:0] rq;
    reg  [1:0]  rr;
    reg  [29:0] rows [0:5];
    integer     i, n_fail = 0, checks_done = 0;

    always #2.5 CORE_CLK = ~CORE_CLK;

    ssf_status_regs ssf_status_regs_i (
        .CORE_CLK, .RST_N, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
        .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID,
        .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
        .CFG_LOAD_DONE(ev[0]), .CFG_SEC, .CFG_DED, .SELF_TEST_FAULT_EVENT_DONE(ev[1]),
        .SELF_TEST_FAULT_EVENT_FAIL, .STARTUP_CHK_DONE(ev[2]), .STARTUP_CHK_FAIL,
        .REG_FAULT(ev[4]), .OSC_FAULT(ev[5]), .ADDR_SHORT(ev[6]),
        .ADDR_OPEN(ev[7]), .RST_DRIVE, .SAFE_STATE(pins[5]), .RST_READBACK,
        .SUPPLY_PIN(pins[4]), .IRQ_PIN(pins[3]), .LOW_POWER_REQ(pins[2]),
        .POWER_ENABLE(pins[1]), .RAIL_TAG_PIN(pins[0]), .CH_BELOW_OFF,
        .REC_DONE(ev[3]), .TS_RD_CH, .LOG_RD_CH, .LOG_RD_SEQ, .RECORDING_IN_PROGRESS,
        .REC_SEQ, .TS_OVERWRITE, .LOG_OVERWRITE
    );

    ssf_host_model ssf_host_model_i (
        .CORE_CLK, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID,
        .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY,
        .RDATA, .RRESP, .RVALID, .RREADY, .HUNG(hung)
    );

    task end_sim;
        begin
            $display("checks %0d mismatches %0d", checks_done, n_fail);
            if (n_fail == 0 && checks_done > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    task chk(input [33:0] got, input [33:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask

    task rdc(input [5:0] idx, input [7:0] exp);
        begin
            ssf_host_model_i.xfer(1'b0, idx, 8'h00, rq, rr);
            chk({rr, rq}, {`SSF_RESP_OKAY, 24'h0, exp});
        end
    endtask

    task wrc(input [5:0] idx, input [7:0] d);
        ssf_host_model_i.xfer(1'b1, idx, d, rq, rr);
    endtask

    // One-cycle strobes, then one idle edge so strobes never merge
    task pulse(input [7:0] e, input [7:0] t, input [7:0] l);
        begin
            ev <= e;
            TS_RD_CH <= t;
            LOG_RD_CH <= l;
            @(posedge CORE_CLK);
            {ev, TS_RD_CH, LOG_RD_CH} <= 24'h0;
            @(posedge CORE_CLK);
        end
    endtask

    always @(posedge hung) begin
        n_fail = n_fail + 1;
        end_sim;
    end

    initial begin
        // pins {safe, supply, irq, low power, enable, tag}, channels,
        // monitor state, channel-off state
        rows[0] = {6'h10, 8'h01, 8'h20, 8'h01};
        rows[1] = {6'h25, 8'h80, 8'h8a, 8'h80};
        rows[2] = {6'h04, 8'ha5, 8'h08, 8'ha5};
        rows[3] = {6'h02, 8'h5a, 8'h04, 8'h5a};
        rows[4] = {6'h1f, 8'hff, 8'h3e, 8'hff};
        rows[5] = {6'h00, 8'h00, 8'h00, 8'h00};
        repeat (12) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        @(posedge CORE_CLK);
        rdc(`SSF_IDX_TEST, 8'h00);
        rdc(`SSF_IDX_FAULT, 8'h00);
        rdc(`SSF_IDX_REC, 8'h00);
        rdc(`SSF_IDX_CHEN, `SSF_CHEN_RST);
        ssf_host_model_i.xfer(1'b1, 6'h00, 8'hff, rq, rr);
        chk({32'h0, rr}, {32'h0, `SSF_RESP_SLVERR});
        ssf_host_model_i.xfer(1'b0, 6'h00, 8'h00, rq, rr);
        chk({rr, rq}, {`SSF_RESP_SLVERR, 32'h0});
        $display("test reset and unmapped done");
        for (i = 0; i < 6; i = i + 1) begin
            pins <= rows[i][29:24];
            CH_BELOW_OFF <= rows[i][23:16];
            repeat (4) @(posedge CORE_CLK);
            rdc(`SSF_IDX_MON, rows[i][15:8]);
            rdc(`SSF_IDX_OFF, rows[i][7:0]);
        end
        // The rows started a low-power exit recording that is still open
        pulse(8'h08, 8'h00, 8'h00);
        rdc(`SSF_IDX_REC, 8'h52);
        wrc(`SSF_IDX_ACK, 8'h12);
        rdc(`SSF_IDX_REC, 8'h40);
        $display("test pin table done");
        {CFG_SEC, CFG_DED} <= 2'h3;
        pulse(8'h01, 8'h00, 8'h00);
        rdc(`SSF_IDX_TEST, 8'h0c);
        wrc(`SSF_IDX_TEST, 8'h00);
        rdc(`SSF_IDX_TEST, 8'h0c);
        wrc(`SSF_IDX_TEST, 8'h08);
        rdc(`SSF_IDX_TEST, 8'h04);
        SELF_TEST_FAULT_EVENT_FAIL <= 4'h5;
        pulse(8'h02, 8'h00, 8'h00);
        rdc(`SSF_IDX_TEST, 8'h07);
        wrc(`SSF_IDX_RESULT, 8'hff);
        rdc(`SSF_IDX_RESULT, 8'h35);
        rdc(`SSF_IDX_MON, 8'h40);
        wrc(`SSF_IDX_TEST, 8'h07);
        rdc(`SSF_IDX_TEST, 8'h00);
        {CFG_SEC, CFG_DED} <= 2'h0;
        SELF_TEST_FAULT_EVENT_FAIL <= 4'ha;
        pulse(8'h03, 8'h00, 8'h00);
        rdc(`SSF_IDX_TEST, 8'h03);
        rdc(`SSF_IDX_RESULT, 8'h0a);
        $display("test events done");
        STARTUP_CHK_FAIL <= 1'b1;
        pulse(8'hf4, 8'h00, 8'h00);
        rdc(`SSF_IDX_FAULT, 8'hdc);
        wrc(`SSF_IDX_FAULT, 8'hdf);
        STARTUP_CHK_FAIL <= 1'b0;
        pulse(8'h04, 8'h00, 8'h00);
        rdc(`SSF_IDX_FAULT, 8'h00);
        RST_DRIVE <= 1'b1;
        repeat (4) @(posedge CORE_CLK);
        wrc(`SSF_IDX_FAULT, 8'h20);
        rdc(`SSF_IDX_FAULT, 8'h20);
        RST_READBACK <= 1'b1;
        repeat (4) @(posedge CORE_CLK);
        rdc(`SSF_IDX_FAULT, 8'h20);
        wrc(`SSF_IDX_FAULT, 8'h20);
        rdc(`SSF_IDX_FAULT, 8'h00);
        $display("test faults done");
        for (i = 0; i < 4; i = i + 1) begin
            pins[1 + i[1]] <= !i[0];
            repeat (6) @(posedge CORE_CLK);
            chk({RECORDING_IN_PROGRESS, REC_SEQ}, {1'b1, i[1:0]});
            pulse(8'h08, 8'h00, 8'h00);
            rdc(`SSF_IDX_REC, {1'b0, i[1:0], 1'b1, 4'h8>>i});
            wrc(`SSF_IDX_ACK, {3'h0, 1'b1, 4'h8 >> i});
            rdc(`SSF_IDX_REC, {1'b0, i[1:0], 5'h00});
        end
        $display("test sequence codes done");
        wrc(`SSF_IDX_CFG, 8'h03);
        wrc(`SSF_IDX_CHEN, 8'h05);
        wrc(`SSF_IDX_ACK, 8'h80);
        chk({RECORDING_IN_PROGRESS, REC_SEQ}, 34'h4);
        pulse(8'h08, 8'h00, 8'h00);
        wrc(`SSF_IDX_ACK, 8'h80);
        chk({TS_OVERWRITE, LOG_OVERWRITE}, 34'h18);
        pulse(8'h08, 8'h00, 8'h00);
        LOG_RD_SEQ <= 2'h1;
        pulse(8'h00, 8'h01, 8'h05);
        rdc(`SSF_IDX_REC, 8'h18);
        LOG_RD_SEQ <= 2'h0;
        pulse(8'h00, 8'h04, 8'h05);
        rdc(`SSF_IDX_REC, 8'h00);
        $display("test overwrite mode done");
        end_sim;
    end
endmodule
